// file: include/trip_pkg.sv
// Shared constants and carrier types for the trip coincidence interlock
package trip_pkg;
   localparam int PR_CH = 4;
   localparam int IR_CH = 2;
   localparam int SR_CH = 2;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int SYNC_STAGES = 2;

   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] TEST_OFS = 8'h04;
   localparam logic [7:0] STAT_OFS = 8'h08;
   localparam logic [7:0] CAUSE_OFS = 8'h0c;

   localparam int CTRL_HELD_W = 5;
   localparam int CTRL_MAN_TRIP = 5;
   localparam int CTRL_TRIP_RESET = 6;
   localparam int TEST_W = 4;
   localparam int STAT_W = 10;
   localparam int CAUSE_W = 6;

   localparam logic [2:0] VOTE_ABOVE = 3'h2;
   localparam logic [2:0] VOTE_BELOW = 3'h3;
   localparam logic [2:0] PR_COUNT = 3'h4;

   typedef struct packed {
      logic [PR_CH-1:0] pr_high;
      logic [PR_CH-1:0] pr_low;
      logic [PR_CH-1:0] pr_perm;
      logic [PR_CH-1:0] pr_rate;
      logic [IR_CH-1:0] ir_trip;
      logic [IR_CH-1:0] ir_perm;
      logic [SR_CH-1:0] sr_trip;
   } chan_in_t;

   typedef struct packed {
      logic sr_reinst_b;
      logic sr_reinst_a;
      logic sr_byp_req;
      logic ir_block_req;
      logic pr_low_byp_req;
   } ctrl_t;

   typedef struct packed {
      logic [SR_CH-1:0] sr_test;
      logic [IR_CH-1:0] ir_test;
   } test_t;

   typedef struct packed {
      logic sr_test_annunc;
      logic ir_test_annunc;
      logic sr_byp_b;
      logic sr_byp_a;
      logic ir_block;
      logic pr_low_byp;
      logic perm_p6;
      logic perm_p10;
      logic trip_b;
      logic trip_a;
   } stat_t;

   typedef struct packed {
      logic manual;
      logic sr;
      logic ir;
      logic rate;
      logic pr_low;
      logic pr_high;
   } cause_t;

   typedef struct packed {
      logic uv_hold;
      logic shunt_trip;
   } breaker_drive_t;

   localparam ctrl_t CTRL_RST = 5'h00;
   localparam test_t TEST_RST = 4'h0;
   localparam cause_t CAUSE_RST = 6'h00;
   localparam breaker_drive_t DRIVE_TRIPPED = 2'h1;
endpackage

// file: rtl/pin_sync.sv
// Two-stage synchroniser for a vector of asynchronous pin levels
`timescale 1ns/1ps
module pin_sync #(
   parameter int W = 1
) (
   input logic clk,
   input logic reset,
   input logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_r;
   logic [W-1:0] q_r;

   always_ff @(posedge clk) begin
      if (reset) begin
         meta_r <= '0;
         q_r <= '0;
      end else begin
         meta_r <= d;
         q_r <= meta_r;
      end
   end

   assign q = q_r;
endmodule

// file: rtl/trip_train.sv
// One logic train: trip latch and breaker coil drive
`timescale 1ns/1ps
module trip_train
   import trip_pkg::*;
(
   input logic clk,
   input logic reset,
   input logic demand,
   input logic reset_req,
   output logic tripped,
   output trip_pkg::breaker_drive_t drive
);
   import trip_pkg::*;

   logic trip_r;
   breaker_drive_t drive_r;

   // Comes out of reset tripped: a fresh start needs an operator reset
   always_ff @(posedge clk) begin
      if (reset) begin
         trip_r <= 1'b1;
      end else if (demand) begin
         trip_r <= 1'b1;
      end else if (reset_req) begin
         trip_r <= 1'b0;
      end
   end

   // Coil held only while untripped, so a dead output means a trip
   always_ff @(posedge clk) begin
      if (reset) begin
         drive_r <= DRIVE_TRIPPED;
      end else begin
         drive_r.uv_hold <= ~trip_r;
         drive_r.shunt_trip <= trip_r;
      end
   end

   assign tripped = trip_r;
   assign drive = drive_r;

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   a_reset_ignored: assert property (demand && reset_req |=> trip_r)
      else $error("trip reset accepted while demand present");
   a_latch_holds: assert property (trip_r && !reset_req |=> trip_r)
      else $error("trip latch released without reset");
   a_coil_drop: assert property (trip_r |=> !drive_r.uv_hold && drive_r.shunt_trip)
      else $error("breaker coils not set to trip");
   a_coil_hold: assert property (!trip_r |=> drive_r.uv_hold && !drive_r.shunt_trip)
      else $error("breaker coils not held while untripped");
endmodule

// file: rtl/trip_coincidence_interlock.sv
// Coincidence voting, permissive bypasses and trip trains for nuclear trips
// How it works
// - Two of four power range high flux channels trip the reactor.
// - Each power range channel has an always active high and startup low input.
// - Low setting bypass accepted only while two of four exceed the permissive.
// - Low setting bypass drops when three of four fall below the permissive.
// - Either intermediate range channel above setpoint trips the reactor.
// - Intermediate trip block needs two of four above; three below reinstates.
// - Intermediate channels test-bypassable one by one, with annunciation.
// - Either source range channel above setpoint trips the reactor.
// - Source bypass allowed above intermediate permissive; both below reinstates.
// - Power range two of four permissive bypasses source trip automatically.
// - Two switches reinstate source trip below permissive, one per train.
// - Source channels test-bypassable one by one, with annunciation.
// - Two of four positive rate channels trip; this trip is never bypassed.
// - Train A opens trip breaker A and bypass B; B the reverse.
// - A trip drops the undervoltage hold and energizes the shunt coil.
// - Trip stays latched until reset; reset ignored while demand persists.
// - Every reactor trip also raises the turbine trip.
// - Manual trip command trips regardless of automatic conditions.
// - Undervoltage hold outputs de-energize to trip, so power loss trips; shunt coil and turbine trip energize to trip.
`timescale 1ns/1ps
module trip_coincidence_interlock
   import trip_pkg::*;
(
   input logic clk,
   input logic reset,
   input trip_pkg::chan_in_t chan_in,
   input logic [trip_pkg::ADDR_W-1:0] addr,
   input logic [trip_pkg::DATA_W-1:0] wdata,
   input logic wr,
   input logic rd,
   output logic [trip_pkg::DATA_W-1:0] rdata,
   output trip_pkg::breaker_drive_t train_a_trip_breaker,
   output trip_pkg::breaker_drive_t train_b_trip_breaker,
   output trip_pkg::breaker_drive_t train_a_bypass_breaker,
   output trip_pkg::breaker_drive_t train_b_bypass_breaker,
   output logic turbine_trip,
   output logic ir_test_annunc,
   output logic sr_test_annunc
);
   import trip_pkg::*;

   function automatic logic [2:0] count4(input logic [PR_CH-1:0] v);
      logic [2:0] n;
      n = 3'h0;
      for (int i = 0; i < PR_CH; i++) begin
         n = n + {2'h0, v[i]};
      end
      return n;
   endfunction

   // Synchronised channel levels
   chan_in_t s;

   pin_sync #(
      .W($bits(chan_in_t))
   ) u_sync (
      .clk(clk),
      .reset(reset),
      .d(chan_in),
      .q(s)
   );

   // Register file
   ctrl_t ctrl_r;
   test_t test_r;
   cause_t cause_r;
   logic man_trip_r;
   logic trip_reset_r;
   logic [DATA_W-1:0] rdata_r;

   wire sel_ctrl = (addr == CTRL_OFS);
   wire sel_test = (addr == TEST_OFS);
   wire sel_stat = (addr == STAT_OFS);
   wire sel_cause = (addr == CAUSE_OFS);
   wire wr_ctrl = wr && sel_ctrl;
   wire wr_test = wr && sel_test;

   always_ff @(posedge clk) begin
      if (reset) begin
         ctrl_r <= CTRL_RST;
         test_r <= TEST_RST;
      end else begin
         if (wr_ctrl) begin
            ctrl_r <= ctrl_t'(wdata[CTRL_HELD_W-1:0]);
         end
         if (wr_test) begin
            test_r <= test_t'(wdata[TEST_W-1:0]);
         end
      end
   end

   // Command bits act once per write and read back as zero
   always_ff @(posedge clk) begin
      if (reset) begin
         man_trip_r <= 1'b0;
         trip_reset_r <= 1'b0;
      end else begin
         man_trip_r <= wr_ctrl && wdata[CTRL_MAN_TRIP];
         trip_reset_r <= wr_ctrl && wdata[CTRL_TRIP_RESET];
      end
   end

   // Permissives
   wire [2:0] pr_above = count4(s.pr_perm);
   wire [2:0] pr_below = PR_COUNT - pr_above;
   wire p10_on = pr_above >= VOTE_ABOVE;
   wire p10_off = pr_below >= VOTE_BELOW;
   wire p6 = |s.ir_perm;

   // Bypass and block states
   logic pr_low_byp_r;
   logic ir_block_r;
   logic sr_man_byp_r;

   wire pr_low_byp_nxt = ctrl_r.pr_low_byp_req && !p10_off && (pr_low_byp_r || p10_on);
   wire ir_block_nxt = ctrl_r.ir_block_req && !p10_off && (ir_block_r || p10_on);
   wire sr_man_byp_nxt = ctrl_r.sr_byp_req && p6;

   always_ff @(posedge clk) begin
      if (reset) begin
         pr_low_byp_r <= 1'b0;
         ir_block_r <= 1'b0;
         sr_man_byp_r <= 1'b0;
      end else begin
         pr_low_byp_r <= pr_low_byp_nxt;
         ir_block_r <= ir_block_nxt;
         sr_man_byp_r <= sr_man_byp_nxt;
      end
   end

   // Source trip bypass per train: permissive wins over the switches
   wire sr_byp_a = p10_on || (sr_man_byp_r && !ctrl_r.sr_reinst_a);
   wire sr_byp_b = p10_on || (sr_man_byp_r && !ctrl_r.sr_reinst_b);

   // Coincidence votes
   wire vote_pr_high = count4(s.pr_high) >= VOTE_ABOVE;
   wire vote_pr_low = (count4(s.pr_low) >= VOTE_ABOVE) && !pr_low_byp_r;
   wire vote_rate = count4(s.pr_rate) >= VOTE_ABOVE;
   wire vote_ir = |(s.ir_trip & ~test_r.ir_test) && !ir_block_r;
   wire sr_any = |(s.sr_trip & ~test_r.sr_test);

   // Everything common to both trains; only the source term differs
   wire common_demand = vote_pr_high || vote_pr_low || vote_rate || vote_ir || man_trip_r;
   wire demand_a = common_demand || (sr_any && !sr_byp_a);
   wire demand_b = common_demand || (sr_any && !sr_byp_b);

   logic trip_a;
   logic trip_b;
   breaker_drive_t drive_a;
   breaker_drive_t drive_b;

   trip_train u_train_a (
      .clk(clk),
      .reset(reset),
      .demand(demand_a),
      .reset_req(trip_reset_r),
      .tripped(trip_a),
      .drive(drive_a)
   );

   trip_train u_train_b (
      .clk(clk),
      .reset(reset),
      .demand(demand_b),
      .reset_req(trip_reset_r),
      .tripped(trip_b),
      .drive(drive_b)
   );

   // Cross wiring of trains to breakers
   assign train_a_trip_breaker = drive_a;
   assign train_b_bypass_breaker = drive_a;
   assign train_b_trip_breaker = drive_b;
   assign train_a_bypass_breaker = drive_b;

   // Annunciation and turbine trip
   logic turbine_trip_r;
   logic ir_annunc_r;
   logic sr_annunc_r;

   always_ff @(posedge clk) begin
      if (reset) begin
         turbine_trip_r <= 1'b1;
         ir_annunc_r <= 1'b0;
         sr_annunc_r <= 1'b0;
      end else begin
         turbine_trip_r <= trip_a || trip_b;
         ir_annunc_r <= |test_r.ir_test;
         sr_annunc_r <= |test_r.sr_test;
      end
   end

   // Trip causes stick until a reset that the trains accept
   cause_t cause_now;
   assign cause_now = '{manual: man_trip_r, sr: sr_any && !(sr_byp_a && sr_byp_b),
                        ir: vote_ir, rate: vote_rate, pr_low: vote_pr_low,
                        pr_high: vote_pr_high};
   wire cause_clear = trip_reset_r && !demand_a && !demand_b;

   always_ff @(posedge clk) begin
      if (reset) begin
         cause_r <= CAUSE_RST;
      end else if (cause_clear) begin
         cause_r <= cause_now;
      end else begin
         cause_r <= cause_r | cause_now;
      end
   end

   // Read path
   stat_t stat;
   assign stat = '{sr_test_annunc: sr_annunc_r, ir_test_annunc: ir_annunc_r,
                   sr_byp_b: sr_byp_b, sr_byp_a: sr_byp_a, ir_block: ir_block_r,
                   pr_low_byp: pr_low_byp_r, perm_p6: p6, perm_p10: p10_on,
                   trip_b: trip_b, trip_a: trip_a};

   wire [DATA_W-1:0] rd_mux =
      sel_ctrl ? {{(DATA_W-CTRL_HELD_W){1'b0}}, ctrl_r} :
      sel_test ? {{(DATA_W-TEST_W){1'b0}}, test_r} :
      sel_stat ? {{(DATA_W-STAT_W){1'b0}}, stat} :
      sel_cause ? {{(DATA_W-CAUSE_W){1'b0}}, cause_r} :
      {DATA_W{1'b0}};

   // Data valid only in the cycle after the strobe
   always_ff @(posedge clk) begin
      if (reset) begin
         rdata_r <= '0;
      end else if (rd) begin
         rdata_r <= rd_mux;
      end else begin
         rdata_r <= '0;
      end
   end

   assign rdata = rdata_r;
   assign turbine_trip = turbine_trip_r;
   assign ir_test_annunc = ir_annunc_r;
   assign sr_test_annunc = sr_annunc_r;

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   sequence two_high_seen;
      count4(s.pr_high) >= 3'h2;
   endsequence

   sequence both_trains_tripped;
      trip_a && trip_b;
   endsequence

   a_high_flux_vote: assert property (two_high_seen |=> both_trains_tripped)
      else $error("two of four high flux did not trip");
   a_low_vote_live: assert property (count4(s.pr_low) >= 3'h2 && !pr_low_byp_r
                                     |=> both_trains_tripped)
      else $error("low setting vote did not trip");
   a_low_byp_gate: assert property ($rose(pr_low_byp_r) |-> $past(pr_above) >= 3'h2)
      else $error("low setting bypass taken below permissive");
   a_low_byp_drop: assert property (pr_above <= 3'h1 |=> !pr_low_byp_r)
      else $error("low setting bypass kept below permissive");
   a_ir_vote: assert property (|(s.ir_trip & ~test_r.ir_test) && !ir_block_r
                               |=> both_trains_tripped)
      else $error("intermediate range did not trip");
   a_ir_block_drop: assert property (pr_above <= 3'h1 |=> !ir_block_r)
      else $error("intermediate block kept below permissive");
   a_ir_annunc: assert property (|test_r.ir_test |=> ir_annunc_r)
      else $error("intermediate test bypass not annunciated");
   a_sr_vote: assert property (sr_any && !sr_byp_a |=> trip_a)
      else $error("source range did not trip train a");
   a_sr_byp_drop: assert property (s.ir_perm == 2'h0 |=> !sr_man_byp_r)
      else $error("source bypass kept below intermediate permissive");
   a_sr_auto_byp: assert property (pr_above >= 3'h2 |-> sr_byp_a && sr_byp_b)
      else $error("source trip not bypassed at permissive");
   a_sr_reinst_b: assert property (!p10_on && ctrl_r.sr_reinst_b |-> !sr_byp_b)
      else $error("train b switch failed to reinstate source trip");
   a_sr_annunc: assert property (|test_r.sr_test |=> sr_annunc_r)
      else $error("source test bypass not annunciated");
   a_rate_vote: assert property (count4(s.pr_rate) >= 3'h2 |=> both_trains_tripped)
      else $error("rate trip did not trip");
   a_cross_wire: assert property (train_b_bypass_breaker == train_a_trip_breaker
                                  && train_a_bypass_breaker == train_b_trip_breaker)
      else $error("breaker cross wiring wrong");
   a_turbine_follow: assert property ($rose(trip_a) |=> turbine_trip_r)
      else $error("turbine trip not raised");
   a_manual_trip: assert property (wr_ctrl && wdata[CTRL_MAN_TRIP] |-> ##2 both_trains_tripped)
      else $error("manual trip not taken");
   a_coil_dead: assert property (trip_a |-> ##1 !train_a_trip_breaker.uv_hold)
      else $error("undervoltage hold not removed on trip");

   sequence reset_cmd;
      trip_reset_r && !demand_a && !demand_b;
   endsequence

   sequence both_clear;
      !trip_a && !trip_b;
   endsequence

   a_low_byp_req: assert property (!ctrl_r.pr_low_byp_req |=> !pr_low_byp_r)
      else $error("low setting bypass without request");
   a_low_byp_take: assert property (ctrl_r.pr_low_byp_req && p10_on |=> pr_low_byp_r)
      else $error("low setting bypass refused at permissive");
   a_ir_block_gate: assert property ($rose(ir_block_r) |-> $past(pr_above) >= 3'h2)
      else $error("intermediate block taken below permissive");
   a_ir_block_req: assert property (!ctrl_r.ir_block_req |=> !ir_block_r)
      else $error("intermediate block without request");
   a_ir_block_take: assert property (ctrl_r.ir_block_req && p10_on |=> ir_block_r)
      else $error("intermediate block refused at permissive");
   a_sr_byp_gate: assert property ($rose(sr_man_byp_r) |-> $past(s.ir_perm) != 2'h0)
      else $error("source bypass taken below intermediate permissive");
   a_sr_byp_take: assert property (ctrl_r.sr_byp_req && p6 |=> sr_man_byp_r)
      else $error("source bypass refused above intermediate permissive");
   a_sr_reinst_a: assert property (!p10_on && ctrl_r.sr_reinst_a |-> !sr_byp_a)
      else $error("train a switch failed to reinstate source trip");
   a_sr_vote_b: assert property (sr_any && !sr_byp_b |=> trip_b)
      else $error("source range did not trip train b");
   a_ir_annunc_off: assert property (test_r.ir_test == 2'h0 |=> !ir_annunc_r)
      else $error("intermediate annunciation without test bypass");
   a_sr_annunc_off: assert property (test_r.sr_test == 2'h0 |=> !sr_annunc_r)
      else $error("source annunciation without test bypass");
   a_reset_refused: assert property (trip_reset_r && demand_b |=> trip_b)
      else $error("train b reset while demand present");
   a_reset_taken: assert property (trip_reset_r && !demand_a |=> !trip_a)
      else $error("train a reset refused without demand");
   a_reset_release: assert property (reset_cmd |=> both_clear)
      else $error("trains still tripped after accepted reset");
   a_turbine_b: assert property ($rose(trip_b) |=> turbine_trip_r)
      else $error("turbine trip not raised by train b");
   a_turbine_clear: assert property (!trip_a && !trip_b |=> !turbine_trip_r)
      else $error("turbine trip held with both trains reset");
   a_cause_manual: assert property (man_trip_r |=> cause_r.manual)
      else $error("manual trip cause not recorded");
   a_coil_dead_b: assert property (trip_b |-> ##1 !train_b_trip_breaker.uv_hold)
      else $error("train b undervoltage hold not removed on trip");
   a_shunt_b: assert property (trip_b |-> ##1 train_b_trip_breaker.shunt_trip)
      else $error("train b shunt coil not energized on trip");
   a_byp_b_coil: assert property (trip_a |-> ##1 train_b_bypass_breaker.shunt_trip)
      else $error("train a did not open bypass breaker b");
   a_byp_a_coil: assert property (trip_b |-> ##1 train_a_bypass_breaker.shunt_trip)
      else $error("train b did not open bypass breaker a");
endmodule

// file: test/chan_comparators.sv
// Channel comparator model driving the interlock's bistable pins
`timescale 1ns/1ps
module chan_comparators
   import trip_pkg::*;
(
   input logic clk,
   input trip_pkg::chan_in_t level,
   output trip_pkg::chan_in_t pins
);
   // Bistables settle once per clock, so a new level shows one cycle late
   always_ff @(posedge clk) begin
      pins.pr_high <= level.pr_high;
      pins.pr_low <= level.pr_low;
      pins.pr_perm <= level.pr_perm;
      pins.pr_rate <= level.pr_rate;
      pins.ir_trip <= level.ir_trip;
      pins.ir_perm <= level.ir_perm;
      pins.sr_trip <= level.sr_trip;
   end
endmodule

// file: test/test_trip_coincidence_interlock.sv
// Self-checking bench for the trip coincidence interlock
`timescale 1ns/1ps
module test_trip_coincidence_interlock;
   import trip_pkg::*;
   logic clk = 1'b0;
   logic reset = 1'b1;
   chan_in_t req = '0;
   chan_in_t chan_in;
   chan_in_t c;
   logic [ADDR_W-1:0] addr = 8'h00;
   logic [DATA_W-1:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [DATA_W-1:0] rdata;
   logic [DATA_W-1:0] d;
   breaker_drive_t ta, tb, ba, bb;
   logic turbine_trip, ir_test_annunc, sr_test_annunc;
   int failures = 0;
   int n_tests = 0;
   int cycles = 0;
   int seed = 93;
   logic [4:0] ctrl = 5'h00;
   logic [3:0] test = 4'h0;
   logic [1:0] tm = 2'h3;
   logic [9:0] st;

   always #50 clk = ~clk;

   chan_comparators i_chan_comparators (.clk(clk), .level(req), .pins(chan_in));

   trip_coincidence_interlock i_trip_coincidence_interlock (
      .clk(clk), .reset(reset), .chan_in(chan_in), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .train_a_trip_breaker(ta),
      .train_b_trip_breaker(tb), .train_a_bypass_breaker(ba),
      .train_b_bypass_breaker(bb), .turbine_trip(turbine_trip),
      .ir_test_annunc(ir_test_annunc), .sr_test_annunc(sr_test_annunc));

   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // Hang guard: the whole run needs well under this many cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         end_sim();
      end
   end

   task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
      n_tests++;
      if (exp !== got) begin
         failures++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr_reg(logic [7:0] a, logic [31:0] v);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= v;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rd_reg(logic [7:0] a, output logic [31:0] v);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      v = rdata;
   endtask

   function automatic int pc(logic [3:0] v);
      return v[0] + v[1] + v[2] + v[3];
   endfunction

   // Status image from pins and switches; bits 1:0 are the train demands
   function automatic logic [9:0] model(chan_in_t p, logic [4:0] k, logic [3:0] t);
      logic p10, p6, lb, ib, sa, sb, ir, sr, com;
      p10 = pc(p.pr_perm) >= 2;
      p6 = |p.ir_perm;
      lb = k[0] && p10;
      ib = k[1] && p10;
      sa = p10 || (k[2] && p6 && !k[3]);
      sb = p10 || (k[2] && p6 && !k[4]);
      ir = |(p.ir_trip & ~t[1:0]) && !ib;
      sr = |(p.sr_trip & ~t[3:2]);
      com = pc(p.pr_high) >= 2 || (pc(p.pr_low) >= 2 && !lb) || pc(p.pr_rate) >= 2 || ir;
      return {|t[3:2], |t[1:0], sb, sa, ib, lb, p6, p10, com | (sr & !sb), com | (sr & !sa)};
   endfunction

   task automatic check_all(logic [9:0] m);
      st = {m[9:2], tm};
      rd_reg(STAT_OFS, d);
      chk("status", {22'h0, st}, d);
      chk("trip_a", tm[0] ? DRIVE_TRIPPED : 2'h2, ta);
      chk("byp_b", tm[0] ? DRIVE_TRIPPED : 2'h2, bb);
      chk("trip_b", tm[1] ? DRIVE_TRIPPED : 2'h2, tb);
      chk("byp_a", tm[1] ? DRIVE_TRIPPED : 2'h2, ba);
      chk("turbine", |tm, turbine_trip);
      chk("ir_annunc", m[8], ir_test_annunc);
      chk("sr_annunc", m[9], sr_test_annunc);
   endtask

   task automatic step(chan_in_t p);
      logic [9:0] m;
      chan_in_t q;
      // Permissives lead the trip levels, as on a power rise; bypasses are registered
      q = '0;
      q.pr_perm = p.pr_perm;
      q.ir_perm = p.ir_perm;
      @(posedge clk);
      req <= q;
      repeat (4) @(posedge clk);
      req <= p;
      repeat (8) @(posedge clk);
      m = model(p, ctrl, test);
      tm = tm | m[1:0];
      check_all(m);
   endtask

   // Reset is refused for a train whose demand is still present
   task automatic trip_reset(chan_in_t p);
      logic [9:0] m;
      m = model(p, ctrl, test);
      wr_reg(CTRL_OFS, {25'h0, 2'b10, ctrl});
      tm = tm & m[1:0];
      repeat (3) @(posedge clk);
      check_all(m);
   endtask

   initial begin
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      check_all(model('0, ctrl, test));
      @(posedge clk);
      #1;
      chk("rdata_idle", 32'h0, rdata);
      trip_reset('0);
      rd_reg(8'h10, d);
      chk("unmapped", 32'h0, d);
      $display("test reset done");
      wr_reg(CTRL_OFS, 32'h20);
      tm = 2'h3;
      repeat (4) @(posedge clk);
      check_all(model('0, ctrl, test));
      rd_reg(CAUSE_OFS, d);
      chk("cause_manual", 32'h20, d);
      trip_reset('0);
      $display("test manual done");
      for (int i = 0; i < 40; i++) begin
         ctrl = 5'($random(seed));
         test = 4'($random(seed));
         wr_reg(CTRL_OFS, {27'h0, ctrl});
         wr_reg(TEST_OFS, {28'h0, test});
         rd_reg(CTRL_OFS, d);
         chk("ctrl", {27'h0, ctrl}, d);
         rd_reg(TEST_OFS, d);
         chk("test", {28'h0, test}, d);
         c = 22'($random(seed) & $random(seed));
         step(c);
         trip_reset(c);
         // Operator clears the condition before the accepted reset
         step('0);
         trip_reset('0);
      end
      $display("test random done");
      end_sim();
   end
endmodule
